// ==== common/ipmc_pkg.sv ====
package ipmc_pkg;

  // clock and one-second prescale
  localparam int CLOCK_HZ     = 20_000_000;
  localparam int ONE_SECOND_S = 1;
  localparam int SECOND_TICKS = CLOCK_HZ * ONE_SECOND_S;
  localparam int MINUTE_S     = 60;
  localparam int HOUR_S       = 3600;
  localparam int SECS_W       = 15;

  // opcodes
  localparam logic [7:0] OP_IDLE       = 8'hE3;
  localparam logic [7:0] OP_IDLE_ALT   = 8'h97;
  localparam logic [7:0] OP_IDLE_IMM   = 8'hE1;
  localparam logic [7:0] OP_IDLE_IMM_A = 8'h95;

  // head unload signature and reply
  localparam logic [7:0] UNL_FEATURE = 8'h44;
  localparam logic [7:0] UNL_COUNT   = 8'h00;
  localparam logic [7:0] UNL_LBA_LO  = 8'h4C;
  localparam logic [7:0] UNL_LBA_MID = 8'h4E;
  localparam logic [7:0] UNL_LBA_HI  = 8'h55;
  localparam logic [7:0] UNL_REPLY   = 8'hC4;

  // timeout encoding
  localparam logic [7:0] TO_OFF       = 8'h00;
  localparam logic [7:0] TO_SHORT_MAX = 8'hF0;
  localparam logic [7:0] TO_LONG_MAX  = 8'hFB;
  localparam logic [7:0] TO_21M       = 8'hFC;
  localparam logic [7:0] TO_8H        = 8'hFD;
  localparam logic [7:0] TO_RESERVED  = 8'hFE;
  localparam logic [7:0] TO_21M15S    = 8'hFF;
  localparam int TO_SHORT_STEP_S = 5;
  localparam int TO_LONG_STEP_M  = 30;
  localparam int TO_21M_M        = 21;
  localparam int TO_8H_H         = 8;
  localparam int TO_EXTRA_S      = 15;

  // status and error bit positions
  localparam int ST_BUSY  = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK  = 4;
  localparam int ST_ERR   = 0;
  localparam int ER_ABORT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h50;

  // controller register map (byte addresses)
  localparam logic [4:0] REG_CMD      = 5'h00;
  localparam logic [4:0] REG_PARAM0   = 5'h04;
  localparam logic [4:0] REG_PARAM1   = 5'h08;
  localparam logic [4:0] REG_RESULT   = 5'h0C;
  localparam logic [4:0] REG_IRQ_STAT = 5'h10;
  localparam logic [4:0] REG_IRQ_CLR  = 5'h14;
  localparam logic [4:0] REG_IRQ_EN   = 5'h18;
  localparam int CMD_SRST_BIT = 8;
  localparam int RES_PEND_BIT = 24;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_ABORT    = 1;
  localparam int IRQ_W        = 2;

  typedef enum logic [3:0] {
    DS_WAIT = 4'b0001,
    DS_EXEC = 4'b0010,
    DS_SPIN = 4'b0100,
    DS_DONE = 4'b1000
  } ipmc_dstate_e;

  function automatic logic ipmc_is_unload(input logic [7:0] cmd, input logic [7:0] feat,
                                          input logic [7:0] cnt, input logic [7:0] lo,
                                          input logic [7:0] mid, input logic [7:0] hi);
    return (cmd == OP_IDLE_IMM || cmd == OP_IDLE_IMM_A) && feat == UNL_FEATURE &&
           cnt == UNL_COUNT && lo == UNL_LBA_LO && mid == UNL_LBA_MID && hi == UNL_LBA_HI;
  endfunction

  function automatic logic [SECS_W-1:0] ipmc_timeout_secs(input logic [7:0] v);
    int s;
    s = 0;
    if (v == TO_OFF)
      s = 0;
    else if (v <= TO_SHORT_MAX)
      s = int'(v) * TO_SHORT_STEP_S;
    else if (v <= TO_LONG_MAX)
      s = (int'(v) - int'(TO_SHORT_MAX)) * TO_LONG_STEP_M * MINUTE_S;
    else if (v == TO_21M)
      s = TO_21M_M * MINUTE_S;
    else if (v == TO_8H)
      s = TO_8H_H * HOUR_S;
    else if (v == TO_21M15S)
      s = TO_21M_M * MINUTE_S + TO_EXTRA_S;
    return SECS_W'(s);
  endfunction

endpackage

// ==== common/ipmc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ipmc_if;
  logic       cmd_valid;
  logic [7:0] cmd_code;
  logic [7:0] feature;
  logic [7:0] count;
  logic [7:0] lba_low;
  logic [7:0] lba_mid;
  logic [7:0] lba_high;
  logic       soft_reset;
  logic       busy;
  logic       done;
  logic [7:0] status;
  logic [7:0] error;
  logic [7:0] lba_low_ret;

  modport host_end (output cmd_valid, cmd_code, feature, count, lba_low, lba_mid, lba_high, soft_reset,
                    input busy, done, status, error, lba_low_ret);
  modport device_end (input cmd_valid, cmd_code, feature, count, lba_low, lba_mid, lba_high, soft_reset,
                      output busy, done, status, error, lba_low_ret);
endinterface
`default_nettype wire

// ==== logic/ipmc_device_end.sv ====
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - E3h and 97h both mean timed idle
// - standby plus timed idle: idle, load timer
// - already idle: power mode stays idle
// - spin-up requested only when spindle stopped
// - idle keeps spindle turning, no wake delay
// - count field zero disables auto standby
// - 1-240 times five; 241-251 half hours
// - 252, 253, 255 fixed; 254 reserved
// - timer expiry without access enters standby
// - any accepted command reloads full interval
// - E1h/95h immediate idle, spin-up if stopped
// - immediate idle keeps programmed timeout
// - unload signature parks heads, replies C4h
// - unload aborts read look-ahead
// - unload suspends cached write flushing
// - flushing resumes on reset or other command
module ipmc_device_end
  import ipmc_pkg::*;
#(
  parameter int TICKS_PER_SEC = SECOND_TICKS
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  ipmc_if.device_end      bus,
  input  wire logic       spindle_spinning,
  output logic            spin_up_req,
  output logic            standby_mode,
  output logic            heads_unload,
  output logic            read_ahead_abort,
  output logic            flush_suspend,
  output logic            timer_running
);

  localparam int PRESC_W = $clog2(TICKS_PER_SEC + 1);

  ipmc_dstate_e           state;
  logic                   spin_meta;
  logic                   spin_sync;
  logic [7:0]             cmd_q;
  logic [7:0]             feat_q;
  logic [7:0]             count_q;
  logic [7:0]             lo_q;
  logic [7:0]             mid_q;
  logic [7:0]             hi_q;
  logic                   abort_q;
  logic                   unload_q;
  logic [SECS_W-1:0]      interval;
  logic [SECS_W-1:0]      secs_left;
  logic [PRESC_W-1:0]     presc;
  logic                   take;
  logic                   is_timed;
  logic                   is_imm;
  logic                   is_unload;
  logic                   reject;
  logic                   sec_tick;
  logic                   expire;

  // spindle state arrives from the motor controller, outside this clock
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      spin_meta <= 1'b0;
      spin_sync <= 1'b0;
    end
    else
    begin
      spin_meta <= spindle_spinning;
      spin_sync <= spin_meta;
    end
  end

  assign take      = bus.cmd_valid && state == DS_WAIT;
  assign is_timed  = cmd_q == OP_IDLE || cmd_q == OP_IDLE_ALT;
  assign is_imm    = cmd_q == OP_IDLE_IMM || cmd_q == OP_IDLE_IMM_A;
  assign is_unload = ipmc_is_unload(cmd_q, feat_q, count_q, lo_q, mid_q, hi_q);
  assign reject    = !(is_timed || is_imm) || (is_timed && count_q == TO_RESERVED);
  assign sec_tick  = presc == PRESC_W'(TICKS_PER_SEC - 1);
  // counting pauses while a command runs; the take reloads it anyway
  assign expire    = timer_running && state == DS_WAIT && sec_tick && secs_left == SECS_W'(1);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cmd_q   <= 8'h00;
      feat_q  <= 8'h00;
      count_q <= 8'h00;
      lo_q    <= 8'h00;
      mid_q   <= 8'h00;
      hi_q    <= 8'h00;
    end
    else if (take)
    begin
      cmd_q   <= bus.cmd_code;
      feat_q  <= bus.feature;
      count_q <= bus.count;
      lo_q    <= bus.lba_low;
      mid_q   <= bus.lba_mid;
      hi_q    <= bus.lba_high;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state       <= DS_WAIT;
      abort_q     <= 1'b0;
      unload_q    <= 1'b0;
      spin_up_req <= 1'b0;
    end
    else
    begin
      unique case (state)
        DS_WAIT:
        begin
          if (take)
            state <= DS_EXEC;
        end
        DS_EXEC:
        begin
          abort_q  <= reject;
          unload_q <= is_unload && !reject;
          if (reject || is_unload)
            state <= DS_DONE;
          else if (spin_sync)
            state <= DS_DONE;
          else
          begin
            spin_up_req <= 1'b1;
            state       <= DS_SPIN;
          end
        end
        DS_SPIN:
        begin
          if (spin_sync)
          begin
            spin_up_req <= 1'b0;
            state       <= DS_DONE;
          end
        end
        DS_DONE:
          state <= DS_WAIT;
      endcase
    end
  end

  // power mode: left only by a command, entered only by reset or expiry
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      standby_mode <= 1'b1;
    else if (state == DS_EXEC && !reject && !is_unload)
      standby_mode <= 1'b0;
    else if (expire)
      standby_mode <= 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      interval      <= '0;
      timer_running <= 1'b0;
      secs_left     <= '0;
      presc         <= '0;
    end
    else if (state == DS_EXEC && is_timed && !reject)
    begin
      interval      <= ipmc_timeout_secs(count_q);
      timer_running <= count_q != TO_OFF;
      secs_left     <= ipmc_timeout_secs(count_q);
      presc         <= '0;
    end
    else if (take)
    begin
      secs_left <= interval;
      presc     <= '0;
    end
    else if (timer_running && state == DS_WAIT && !standby_mode)
    begin
      if (sec_tick)
      begin
        presc <= '0;
        if (expire)
          secs_left <= interval;
        else
          secs_left <= secs_left - SECS_W'(1);
      end
      else
        presc <= presc + PRESC_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      heads_unload     <= 1'b0;
      read_ahead_abort <= 1'b0;
      flush_suspend    <= 1'b0;
    end
    else
    begin
      heads_unload     <= state == DS_EXEC && is_unload;
      read_ahead_abort <= state == DS_EXEC && is_unload;
      if (bus.soft_reset)
        flush_suspend <= 1'b0;
      else if (state == DS_EXEC && is_unload)
        flush_suspend <= 1'b1;
      else if (take && !ipmc_is_unload(bus.cmd_code, bus.feature, bus.count, bus.lba_low, bus.lba_mid,
                                       bus.lba_high))
        flush_suspend <= 1'b0;
    end
  end

  // task-file answer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus.busy        <= 1'b0;
      bus.done        <= 1'b0;
      bus.status      <= STATUS_RESET;
      bus.error       <= 8'h00;
      bus.lba_low_ret <= 8'h00;
    end
    else
    begin
      bus.done <= state == DS_DONE;
      if (take)
      begin
        bus.busy   <= 1'b1;
        bus.status <= 8'h00;
        bus.status[ST_BUSY] <= 1'b1;
      end
      else if (state == DS_DONE)
      begin
        bus.busy   <= 1'b0;
        bus.status <= 8'h00;
        bus.status[ST_READY] <= 1'b1;
        bus.status[ST_SEEK]  <= 1'b1;
        bus.status[ST_ERR]   <= abort_q;
        bus.error  <= 8'h00;
        bus.error[ER_ABORT]  <= abort_q;
        bus.lba_low_ret <= unload_q ? UNL_REPLY : lo_q;
      end
    end
  end

endmodule // ipmc_device_end
`default_nettype wire

// ==== logic/ipmc_host_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module ipmc_host_end
  import ipmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  ipmc_if.host_end         bus,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  logic                    pending;
  logic [7:0]              res_status;
  logic [7:0]              res_error;
  logic [7:0]              res_lba;
  logic [IRQ_W-1:0]        irq_stat;
  logic [IRQ_W-1:0]        irq_en;
  logic                    wr_go;
  logic                    issue;
  logic [IRQ_W-1:0]        irq_set;
  logic [31:0]             rd_mux;

  assign wr_go   = avs_write && !avs_waitrequest;
  // a command while one is still open is dropped, the result register tells why
  assign issue   = wr_go && avs_address == REG_CMD && !avs_writedata[CMD_SRST_BIT] && !pending && !bus.busy;
  assign irq_set = {bus.done && bus.error[ER_ABORT], bus.done};

  // one wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      REG_CMD:      rd_mux = {24'h00_0000, bus.cmd_code};
      REG_PARAM0:   rd_mux = {bus.lba_mid, bus.lba_low, bus.count, bus.feature};
      REG_PARAM1:   rd_mux = {24'h00_0000, bus.lba_high};
      REG_RESULT:   rd_mux = {7'h00, pending, res_lba, res_error, res_status};
      REG_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat};
      REG_IRQ_EN:   rd_mux = {30'h0000_0000, irq_en};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= rd_mux;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus.cmd_code <= 8'h00;
      bus.feature  <= 8'h00;
      bus.count    <= 8'h00;
      bus.lba_low  <= 8'h00;
      bus.lba_mid  <= 8'h00;
      bus.lba_high <= 8'h00;
      irq_en       <= '0;
    end
    else if (wr_go)
    begin
      if (issue)
        bus.cmd_code <= avs_writedata[7:0];
      if (avs_address == REG_PARAM0)
      begin
        bus.feature <= avs_writedata[7:0];
        bus.count   <= avs_writedata[15:8];
        bus.lba_low <= avs_writedata[23:16];
        bus.lba_mid <= avs_writedata[31:24];
      end
      if (avs_address == REG_PARAM1)
        bus.lba_high <= avs_writedata[7:0];
      if (avs_address == REG_IRQ_EN)
        irq_en <= avs_writedata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus.cmd_valid  <= 1'b0;
      bus.soft_reset <= 1'b0;
      pending        <= 1'b0;
    end
    else
    begin
      bus.cmd_valid  <= issue;
      bus.soft_reset <= wr_go && avs_address == REG_CMD && avs_writedata[CMD_SRST_BIT];
      if (issue)
        pending <= 1'b1;
      else if (bus.done)
        pending <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      res_status <= STATUS_RESET;
      res_error  <= 8'h00;
      res_lba    <= 8'h00;
    end
    else if (bus.done)
    begin
      res_status <= bus.status;
      res_error  <= bus.error;
      res_lba    <= bus.lba_low_ret;
    end
  end

  // set beats clear in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_stat <= '0;
    else if (wr_go && avs_address == REG_IRQ_CLR)
      irq_stat <= (irq_stat & ~avs_writedata[IRQ_W-1:0]) | irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_en);
  end

endmodule // ipmc_host_end
`default_nettype wire

// ==== testbench/ipmc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module ipmc_checker
  import ipmc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] feature,
  input wire logic [7:0] count,
  input wire logic [7:0] lba_low,
  input wire logic [7:0] lba_mid,
  input wire logic [7:0] lba_high,
  input wire logic       busy,
  input wire logic       done,
  input wire logic [7:0] status,
  input wire logic [7:0] error,
  input wire logic [7:0] lba_low_ret
);
  logic take;
  logic known;
  logic unl;
  assign take  = cmd_valid && !busy;
  assign known = cmd_code inside {OP_IDLE, OP_IDLE_ALT, OP_IDLE_IMM, OP_IDLE_IMM_A};
  assign unl   = (cmd_code == OP_IDLE_IMM || cmd_code == OP_IDLE_IMM_A) && feature == UNL_FEATURE &&
                 count == UNL_COUNT && lba_low == UNL_LBA_LO && lba_mid == UNL_LBA_MID && lba_high == UNL_LBA_HI;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_take_sets_busy: assert property (take |=> busy)
    else $error("busy not raised after a command");
  a_done_ends_busy: assert property (done |-> !busy && $past(busy))
    else $error("done without a busy command");
  a_done_one_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_busy_in_status: assert property (busy |-> status[ST_BUSY])
    else $error("status busy bit low while busy");
  a_done_ready_ok: assert property (done && !error[ER_ABORT] |-> status[ST_READY] && status[ST_SEEK] &&
    !status[ST_FAULT] && !status[ST_BUSY] && !status[ST_ERR] && error == 8'h00)
    else $error("completion status wrong");
  a_abort_err_sum: assert property (done && error[ER_ABORT] |-> status[ST_ERR] && !status[ST_BUSY])
    else $error("abort without error summary");
  a_reserved_abort: assert property (take && (cmd_code == OP_IDLE || cmd_code == OP_IDLE_ALT) &&
    count == TO_RESERVED |-> ##[1:6] (done && error[ER_ABORT]))
    else $error("reserved timeout not aborted");
  a_unknown_abort: assert property (take && !known |-> ##[1:6] (done && error[ER_ABORT]))
    else $error("unknown opcode not aborted");
  a_unload_reply: assert property (take && unl |-> ##[1:6] (done && lba_low_ret == UNL_REPLY))
    else $error("unload reply missing");
  c_unload: cover property (take && unl);
  c_abort: cover property (done && error[ER_ABORT]);
  c_good: cover property (done && !error[ER_ABORT]);
endmodule // ipmc_checker
`default_nettype wire

// ==== testbench/idle_power_mode_commands_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module idle_power_mode_commands_tb_top;
  import ipmc_pkg::*;
  // short second keeps the longest tested interval under eight thousand cycles
  localparam int TPS = 4;
  logic        clock = 1'h0;
  logic        rst = 1'h1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        spindle_spinning = 1'h0;
  logic        spin_up_req, standby_mode, heads_unload, read_ahead_abort, flush_suspend, timer_running;
  logic        sp_q = 1'h0;
  logic [31:0] q;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          spin_cnt = 0;
  int          pulse_cnt = 0;
  logic [7:0]  tv [5] = '{8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFF};
  int          ts [5] = '{5, 1200, 1800, 1260, 1275};

  ipmc_if ipmc_if_i ();
  ipmc_host_end ipmc_host_end_i (.clock(clock), .rst(rst), .bus(ipmc_if_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  ipmc_device_end #(.TICKS_PER_SEC(TPS)) ipmc_device_end_i (.clock(clock), .rst(rst), .bus(ipmc_if_i),
    .spindle_spinning(spindle_spinning), .spin_up_req(spin_up_req), .standby_mode(standby_mode),
    .heads_unload(heads_unload), .read_ahead_abort(read_ahead_abort), .flush_suspend(flush_suspend),
    .timer_running(timer_running));
  ipmc_checker ipmc_checker_i (.clock(clock), .rst(rst), .cmd_valid(ipmc_if_i.cmd_valid),
    .cmd_code(ipmc_if_i.cmd_code), .feature(ipmc_if_i.feature), .count(ipmc_if_i.count),
    .lba_low(ipmc_if_i.lba_low), .lba_mid(ipmc_if_i.lba_mid), .lba_high(ipmc_if_i.lba_high),
    .busy(ipmc_if_i.busy), .done(ipmc_if_i.done), .status(ipmc_if_i.status), .error(ipmc_if_i.error),
    .lba_low_ret(ipmc_if_i.lba_low_ret));

  always #25 clock = ~clock;

  // motor stand-in: spins up on request and never stops
  always @(posedge clock)
  begin
    sp_q <= spin_up_req;
    if (spin_up_req === 1'h1)
      spindle_spinning <= 1'h1;
    if (spin_up_req === 1'h1 && sp_q !== 1'h1)
      spin_cnt <= spin_cnt + 1;
    pulse_cnt <= pulse_cnt + int'(read_ahead_abort === 1'h1) + int'(heads_unload === 1'h1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    summarize();
  endtask

  // registered outputs are read before this edge's updates land
  task automatic acc(input logic we, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= we;
    avs_read      <= !we;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 50);
    if (avs_waitrequest !== 1'h0)
      hang();
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask

  task automatic run(input logic [7:0] op, input logic [31:0] p0, input logic [7:0] p1);
    int n;
    acc(1'h1, REG_PARAM0, p0);
    acc(1'h1, REG_PARAM1, {24'h0, p1});
    acc(1'h1, REG_CMD, {24'h0, op});
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ipmc_if_i.done !== 1'h1 && n < 200);
    if (ipmc_if_i.done !== 1'h1)
      hang();
    acc(1'h0, REG_RESULT, 32'h0);
  endtask

  task automatic expire(input int secs);
    int n;
    n = 0;
    while (standby_mode !== 1'h1 && n < 8000)
    begin
      @(posedge clock);
      n++;
    end
    chk(32'(n + 8 >= secs * TPS && n <= secs * TPS + 8), 32'h1);
    if (standby_mode !== 1'h1)
      hang();
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    acc(1'h0, REG_RESULT, 32'h0);
    chk(q, {24'h0, STATUS_RESET});
    acc(1'h0, REG_IRQ_EN, 32'h0);
    chk(q, 32'h0);
    acc(1'h0, 5'h1C, 32'h0);
    chk(q, 32'h0);
    chk(standby_mode, 1'h1);
    acc(1'h1, REG_IRQ_EN, 32'h3);
    $display("test registers done");
    foreach (tv[i])
    begin
      run(OP_IDLE, {16'h0, tv[i], 8'h00}, 8'h00);
      chk(q, {24'h0, STATUS_RESET});
      chk({standby_mode, timer_running}, 2'h1);
      expire(ts[i]);
    end
    chk(spin_cnt, 1);
    acc(1'h0, REG_IRQ_STAT, 32'h0);
    chk(q, 32'h1);
    chk(irq, 1'h1);
    acc(1'h1, REG_IRQ_CLR, 32'h3);
    acc(1'h0, REG_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'h0);
    $display("test decode done");
    run(OP_IDLE_ALT, 32'h0, 8'h00);
    chk({standby_mode, timer_running}, 2'h0);
    repeat (100) @(posedge clock);
    chk(standby_mode, 1'h0);
    run(OP_IDLE, 32'h0000_0100, 8'h00);
    chk({standby_mode, timer_running}, 2'h1);
    // issued before the short interval runs out, so expiry must be pushed back
    run(OP_IDLE_IMM_A, 32'h0, 8'h00);
    chk(standby_mode, 1'h0);
    expire(5);
    run(OP_IDLE_IMM, 32'h0, 8'h00);
    chk(standby_mode, 1'h0);
    expire(5);
    chk(spin_cnt, 1);
    $display("test timer done");
    acc(1'h1, REG_IRQ_EN, 32'h0);
    run(OP_IDLE_ALT, {16'h0, TO_RESERVED, 8'h00}, 8'h00);
    chk({q[8 + ER_ABORT], q[ST_ERR], standby_mode}, 3'h7);
    run(8'h00, 32'h0, 8'h00);
    chk({q[8 + ER_ABORT], q[ST_ERR], standby_mode}, 3'h7);
    acc(1'h0, REG_IRQ_STAT, 32'h0);
    chk({q[IRQ_ABORT], irq}, 2'h2);
    acc(1'h1, REG_IRQ_CLR, 32'h3);
    $display("test abort done");
    run(OP_IDLE_IMM, 32'h4E4C_0044, 8'h55);
    chk(q[23:16], UNL_REPLY);
    chk(pulse_cnt, 2);
    chk(flush_suspend, 1'h1);
    acc(1'h0, REG_PARAM0, 32'h0);
    chk(q, 32'h4E4C_0044);
    acc(1'h0, REG_CMD, 32'h0);
    chk(q, {24'h0, OP_IDLE_IMM});
    run(OP_IDLE_IMM_A, 32'h4E4C_0044, 8'h55);
    chk({pulse_cnt[7:0], flush_suspend}, {8'h04, 1'h1});
    acc(1'h1, REG_CMD, 32'h100);
    repeat (4) @(posedge clock);
    chk(flush_suspend, 1'h0);
    run(OP_IDLE_IMM, 32'h4E4C_0044, 8'h55);
    run(OP_IDLE_IMM, 32'h0, 8'h00);
    chk(flush_suspend, 1'h0);
    run(OP_IDLE_IMM, 32'h4E4C_0044, 8'h55);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    chk(flush_suspend, 1'h0);
    $display("test unload done");
    summarize();
  end
endmodule // idle_power_mode_commands_tb_top
`default_nettype wire
